/* hw/pmc_pkg.sv */
// shared constants for the power-mode and clock-tree controller
package pmc_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] OFS_ACTIVE_GATE = 8'h38;
  localparam logic [7:0] OFS_ACTIVE_CLOCK = 8'h3C;
  localparam logic [7:0] OFS_MODE0_GATE = 8'h40;
  localparam logic [7:0] OFS_MODE0_FREQ = 8'h44;
  localparam logic [7:0] OFS_MODE1_GATE = 8'h48;
  localparam logic [7:0] OFS_MODE1_FREQ = 8'h4C;
  localparam logic [7:0] OFS_SLEEP_GATE = 8'h50;
  localparam logic [7:0] OFS_MODE_SELECT = 8'h54;
  localparam logic [7:0] OFS_PLL_TALLY = 8'h64;
  localparam logic [7:0] OFS_MISC_TIMING = 8'h68;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [31:0] RST_GATE = 32'h00021807;
  localparam logic [31:0] RST_FREQ = 32'h2A1A0A09;
  localparam logic [31:0] RST_SLEEP_GATE = 32'h00018000;
  localparam logic [31:0] RST_MODE_SELECT = 32'h00000000;
  localparam logic [31:0] RST_MISC_TIMING = 32'h00090900;

  // ****************************************************************
  // field positions and masks
  // ****************************************************************
  localparam int GATE_BITS = 7;
  localparam logic [31:0] MASK_GATE = 32'h0000007F;
  localparam logic [31:0] MASK_FREQ = 32'hFF3F1F1F;
  localparam logic [31:0] MASK_SLEEP_GATE = 32'h00786000;
  localparam logic [31:0] MASK_MISC = 32'hF31F1F47;
  localparam int MODE_LSB = 0;
  localparam int SLEEP_STATUS_BIT = 2;
  localparam int RECOVERY_LSB = 13;
  localparam int ACPI_ENABLE_BIT = 6;
  localparam int SYSMEM_M0_LSB = 8;
  localparam int SYSMEM_M1_LSB = 16;
  localparam int SYSMEM_BITS = 5;
  localparam int TALLY_BITS = 16;

  // ****************************************************************
  // mode codes
  // ****************************************************************
  localparam logic [1:0] MODE_OP0 = 2'h0;
  localparam logic [1:0] MODE_OP1 = 2'h1;
  localparam logic [1:0] MODE_SLEEP = 2'h2;
  localparam logic [1:0] MODE_RESERVED = 2'h3;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int PCLK_MHZ = 200;
  localparam int RECOVERY_TICK_US = 32;
  localparam int RECOVERY_TICK_CYCLES = RECOVERY_TICK_US * PCLK_MHZ;
  localparam int TICKS_PER_STEP = 32;
  localparam int TICK_DIV_BITS = 16;

  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_SLEEP = 3'b010,
    ST_RECOVER = 3'b100
  } power_state_t;

endpackage : pmc_pkg

/* hw/power_mode_clock_control.sv */
// power-mode and clock-tree controller with apb register slave
// ****************************************************************
// ****************************************************************
`timescale 1ns/1ps
`default_nettype none

module power_mode_clock_control
  import pmc_pkg::*;
#(
  parameter int TICK_CYCLES = RECOVERY_TICK_CYCLES
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] acpi_power_state,
  input wire logic [1:0] double_rate_tick,
  output logic [1:0] pixel_tick,
  output logic [GATE_BITS-1:0] block_clock_enable,
  output logic [31:0] branch_clock_setting,
  output logic [SYSMEM_BITS-1:0] system_memory_clock,
  output logic oscillator_enable,
  output logic times_four_multiplier,
  output logic times_six_multiplier,
  output logic times_seven_multiplier,
  output logic sleep_status
);

  // ****************************************************************
  // storage and decode
  // ****************************************************************
  logic [31:0] mode0_gating;
  logic [31:0] mode0_frequency;
  logic [31:0] mode1_gating;
  logic [31:0] mode1_frequency;
  logic [31:0] sleep_gating;
  logic [1:0] mode_field;
  logic [31:0] misc_timing_control;
  logic [TALLY_BITS-1:0] pll_run_tally;
  logic active_mode1;
  power_state_t state;
  power_state_t next_state;
  logic [TICK_DIV_BITS-1:0] tick_div;
  logic [7:0] tick_count;
  logic [1:0] pixel_phase;
  logic acpi_q1;
  logic acpi_q2;
  logic access;
  logic wr_en;
  logic sleep_request;
  logic recovery_done;
  logic [31:0] read_value;
  logic [31:0] active_gate_mirror;
  logic [31:0] active_clock_mirror;

  function automatic logic hit(input logic [31:0] addr,
                               input logic [7:0] ofs);
    hit = (addr[31:8] == 24'h000000) && (addr[7:0] == ofs);
  endfunction : hit

  function automatic logic [7:0] recovery_ticks(input logic [1:0] sel);
    recovery_ticks = 8'((int'(sel) + 1) * TICKS_PER_STEP);
  endfunction : recovery_ticks

  assign access = psel && penable && pready;
  assign wr_en = access && pwrite;

  // mirrors follow the active mode, which holds its last operating mode while sleep is selected
  assign active_gate_mirror = active_mode1 ? mode1_gating : mode0_gating;
  assign active_clock_mirror = active_mode1 ? mode1_frequency
                                            : mode0_frequency;

  // acpi power-state input is another block's state: sync before use
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acpi_q1 <= 1'b0;
      acpi_q2 <= 1'b0;
    end
    else
    begin
      acpi_q1 <= acpi_power_state[1];
      acpi_q2 <= acpi_q1;
    end
  end

  assign sleep_request = misc_timing_control[ACPI_ENABLE_BIT]
                         ? acpi_q2
                         : (mode_field == MODE_SLEEP);

  // ****************************************************************
  // apb slave: one wait state
  // ****************************************************************
  always_comb
  begin
    read_value = 32'h00000000;
    case (1'b1)
      hit(paddr, OFS_ACTIVE_GATE): read_value = active_gate_mirror;
      hit(paddr, OFS_ACTIVE_CLOCK): read_value = active_clock_mirror;
      hit(paddr, OFS_MODE0_GATE): read_value = mode0_gating;
      hit(paddr, OFS_MODE0_FREQ): read_value = mode0_frequency;
      hit(paddr, OFS_MODE1_GATE): read_value = mode1_gating;
      hit(paddr, OFS_MODE1_FREQ): read_value = mode1_frequency;
      hit(paddr, OFS_SLEEP_GATE): read_value = sleep_gating;
      hit(paddr, OFS_MODE_SELECT):
        read_value = {29'h0, sleep_status, mode_field};
      hit(paddr, OFS_PLL_TALLY): read_value = {16'h0, pll_run_tally};
      hit(paddr, OFS_MISC_TIMING): read_value = misc_timing_control;
      default: read_value = 32'h00000000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready)
      begin
        prdata <= pwrite ? 32'h00000000 : read_value;
        pslverr <= (read_value == 32'h0) && !(
          hit(paddr, OFS_ACTIVE_GATE) || hit(paddr, OFS_ACTIVE_CLOCK) ||
          hit(paddr, OFS_MODE0_GATE) || hit(paddr, OFS_MODE0_FREQ) ||
          hit(paddr, OFS_MODE1_GATE) || hit(paddr, OFS_MODE1_FREQ) ||
          hit(paddr, OFS_SLEEP_GATE) || hit(paddr, OFS_MODE_SELECT) ||
          hit(paddr, OFS_PLL_TALLY) || hit(paddr, OFS_MISC_TIMING));
      end
      else
      begin
        pslverr <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // writable registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode0_gating <= RST_GATE;
      mode1_gating <= RST_GATE;
      mode0_frequency <= RST_FREQ;
      mode1_frequency <= RST_FREQ;
      sleep_gating <= RST_SLEEP_GATE;
      misc_timing_control <= RST_MISC_TIMING;
    end
    else if (wr_en)
    begin
      if (hit(paddr, OFS_MODE0_GATE))
        mode0_gating <= pwdata & MASK_GATE;
      if (hit(paddr, OFS_MODE1_GATE))
        mode1_gating <= pwdata & MASK_GATE;
      if (hit(paddr, OFS_MODE0_FREQ))
        mode0_frequency <= pwdata & MASK_FREQ;
      if (hit(paddr, OFS_MODE1_FREQ))
        mode1_frequency <= pwdata & MASK_FREQ;
      if (hit(paddr, OFS_SLEEP_GATE))
        sleep_gating <= pwdata & MASK_SLEEP_GATE;
      if (hit(paddr, OFS_MISC_TIMING))
        misc_timing_control <= pwdata & MASK_MISC;
    end
  end

  // status bit is not writable; reserved code is dropped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_field <= RST_MODE_SELECT[1:0];
    else if (wr_en && hit(paddr, OFS_MODE_SELECT)
             && pwdata[1:0] != MODE_RESERVED)
      mode_field <= pwdata[1:0];
  end

  // ****************************************************************
  // sleep sequencing
  // ****************************************************************
  assign recovery_done = (tick_count == recovery_ticks(
                           sleep_gating[RECOVERY_LSB +: 2]));

  always_comb
  begin
    next_state = state;
    case (state)
      ST_RUN:
        if (sleep_request)
          next_state = ST_SLEEP;
      ST_SLEEP:
        if (!sleep_request)
          next_state = ST_RECOVER;
      ST_RECOVER:
        if (sleep_request)
          next_state = ST_SLEEP;
        else if (recovery_done)
          next_state = ST_RUN;
      default:
        next_state = ST_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= ST_RUN;
    else
      state <= next_state;
  end

  // 32 us tick and tick tally during recovery
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_div <= '0;
      tick_count <= 8'h00;
    end
    else if (state != ST_RECOVER)
    begin
      tick_div <= '0;
      tick_count <= 8'h00;
    end
    else if (tick_div == TICK_DIV_BITS'(TICK_CYCLES - 1))
    begin
      tick_div <= '0;
      tick_count <= tick_count + 8'h01;
    end
    else
    begin
      tick_div <= tick_div + 1'b1;
    end
  end

  // active mode only moves while clocks run
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      active_mode1 <= 1'b0;
    else if (state == ST_RUN && mode_field != MODE_SLEEP)
      active_mode1 <= (mode_field == MODE_OP1);
  end

  // ****************************************************************
  // clock tree outputs
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sleep_status <= 1'b0;
      oscillator_enable <= 1'b1;
      times_four_multiplier <= 1'b1;
      times_six_multiplier <= 1'b1;
      times_seven_multiplier <= 1'b1;
      block_clock_enable <= RST_GATE[GATE_BITS-1:0];
      branch_clock_setting <= RST_FREQ;
      system_memory_clock <= RST_MISC_TIMING[SYSMEM_M0_LSB +: SYSMEM_BITS];
    end
    else
    begin
      sleep_status <= (next_state != ST_RUN);
      oscillator_enable <= (next_state != ST_SLEEP);
      times_four_multiplier <= (next_state != ST_SLEEP);
      times_six_multiplier <= (next_state != ST_SLEEP);
      times_seven_multiplier <= (next_state != ST_SLEEP);
      if (next_state != ST_RUN)
        block_clock_enable <= '0;
      else
        block_clock_enable <= active_gate_mirror[GATE_BITS-1:0];
      branch_clock_setting <= active_clock_mirror;
      system_memory_clock <= active_mode1
        ? misc_timing_control[SYSMEM_M1_LSB +: SYSMEM_BITS]
        : misc_timing_control[SYSMEM_M0_LSB +: SYSMEM_BITS];
    end
  end

  // clocks counted since the plls were last switched on
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pll_run_tally <= '0;
    else if (state == ST_SLEEP)
      pll_run_tally <= '0;
    else
      pll_run_tally <= pll_run_tally + 1'b1;
  end

  // ****************************************************************
  // pixel rate: every second double-rate tick
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_pixel
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          pixel_phase[g] <= 1'b0;
          pixel_tick[g] <= 1'b0;
        end
        else
        begin
          if (double_rate_tick[g] && block_clock_enable[2])
            pixel_phase[g] <= !pixel_phase[g];
          pixel_tick[g] <= double_rate_tick[g] && block_clock_enable[2]
                           && pixel_phase[g];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_sleep_stops;
    @(posedge pclk) disable iff (!presetn)
    state == ST_SLEEP |-> !oscillator_enable && !times_four_multiplier
                          && block_clock_enable == '0;
  endproperty
  a_sleep_stops: assert property (p_sleep_stops)
    else $error("clocks running in sleep");

  property p_enter_sleep;
    @(posedge pclk) disable iff (!presetn)
    state == ST_RUN && !misc_timing_control[ACPI_ENABLE_BIT]
      && mode_field == MODE_SLEEP |=> state == ST_SLEEP ##0 sleep_status;
  endproperty
  a_enter_sleep: assert property (p_enter_sleep)
    else $error("mode 10 did not enter sleep");

  property p_status_read;
    @(posedge pclk) disable iff (!presetn)
    psel && penable && !pready && !pwrite && hit(paddr, OFS_MODE_SELECT)
      |=> prdata[SLEEP_STATUS_BIT] == $past(sleep_status);
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("sleep status read wrong");

  property p_mode0_mirror;
    @(posedge pclk) disable iff (!presetn)
    !active_mode1 |=> branch_clock_setting == $past(mode0_frequency);
  endproperty
  a_mode0_mirror: assert property (p_mode0_mirror)
    else $error("mode 0 clock not applied");

  property p_mode1_mirror;
    @(posedge pclk) disable iff (!presetn)
    active_mode1 && state == ST_RUN ##1 state == ST_RUN
      |-> block_clock_enable == $past(mode1_gating[GATE_BITS-1:0]);
  endproperty
  a_mode1_mirror: assert property (p_mode1_mirror)
    else $error("mode 1 gating not applied");

  property p_sysmem;
    @(posedge pclk) disable iff (!presetn)
    ##1 system_memory_clock == ($past(active_mode1)
      ? $past(misc_timing_control[20:16])
      : $past(misc_timing_control[12:8]));
  endproperty
  a_sysmem: assert property (p_sysmem)
    else $error("system memory clock field wrong");

  property p_acpi_sleep;
    @(posedge pclk) disable iff (!presetn)
    state == ST_RUN && misc_timing_control[ACPI_ENABLE_BIT] && acpi_q2
      |=> state == ST_SLEEP;
  endproperty
  a_acpi_sleep: assert property (p_acpi_sleep)
    else $error("acpi request did not sleep");

  property p_recover_hold;
    @(posedge pclk) disable iff (!presetn)
    state == ST_RECOVER |-> sleep_status;
  endproperty
  a_recover_hold: assert property (p_recover_hold)
    else $error("status cleared during recovery");

  property p_tally;
    @(posedge pclk) disable iff (!presetn)
    state == ST_RUN ##1 state == ST_RUN
      |-> pll_run_tally == $past(pll_run_tally) + 16'h0001;
  endproperty
  a_tally: assert property (p_tally)
    else $error("tally not counting");

  property p_recover_len;
    @(posedge pclk) disable iff (!presetn)
    state == ST_RECOVER && tick_count < recovery_ticks(
      sleep_gating[RECOVERY_LSB +: 2]) |=> state != ST_RUN;
  endproperty
  a_recover_len: assert property (p_recover_len)
    else $error("recovery ended early");

  c_sleep: cover property (@(posedge pclk) disable iff (!presetn)
    state == ST_SLEEP);
  c_wake: cover property (@(posedge pclk) disable iff (!presetn)
    state == ST_RECOVER ##1 state == ST_RUN);
  c_mode1: cover property (@(posedge pclk) disable iff (!presetn)
    active_mode1 && state == ST_RUN);

endmodule : power_mode_clock_control

`default_nettype wire

/* test/tb_power_mode_clock_control.sv */
// self-checking bench for the power-mode and clock-tree controller
`timescale 1ns/1ps
`default_nettype none

module tb_power_mode_clock_control;
  import pmc_pkg::*;

  // ****************************************************************
  // stimulus and observation
  // ****************************************************************
  typedef struct {
    logic wr;
    logic [31:0] addr;
    logic [31:0] wd;
    logic [31:0] exp;
    logic err;
  } row_t;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h00000000;
  logic [31:0] pwdata = 32'h00000000;
  logic [1:0] acpi_power_state = 2'h0;
  logic [1:0] double_rate_tick = 2'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] pixel_tick;
  logic [GATE_BITS-1:0] block_clock_enable;
  logic [31:0] branch_clock_setting;
  logic [SYSMEM_BITS-1:0] system_memory_clock;
  logic oscillator_enable;
  logic times_four_multiplier;
  logic times_six_multiplier;
  logic times_seven_multiplier;
  logic sleep_status;
  int err_count = 0;
  int checked = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic er;
  logic [31:0] t0;
  int n;

  row_t rows [19] = '{
    '{1'b0, 32'h40, 32'h0, 32'h00021807, 1'b0},
    '{1'b0, 32'h44, 32'h0, 32'h2A1A0A09, 1'b0},
    '{1'b0, 32'h48, 32'h0, 32'h00021807, 1'b0},
    '{1'b0, 32'h4C, 32'h0, 32'h2A1A0A09, 1'b0},
    '{1'b0, 32'h54, 32'h0, 32'h00000000, 1'b0},
    '{1'b0, 32'h38, 32'h0, 32'h00021807, 1'b0},
    '{1'b0, 32'h3C, 32'h0, 32'h2A1A0A09, 1'b0},
    '{1'b0, 32'h68, 32'h0, 32'h00090900, 1'b0},
    '{1'b0, 32'h100, 32'h0, 32'h00000000, 1'b1},
    '{1'b1, 32'h40, 32'hFFFFFFFF, 32'h0000007F, 1'b0},
    '{1'b1, 32'h38, 32'h0, 32'h0000007F, 1'b0},
    '{1'b1, 32'h4C, 32'h2C1C0C0C, 32'h2C1C0C0C, 1'b0},
    '{1'b1, 32'h54, 32'h1, 32'h00000001, 1'b0},
    '{1'b0, 32'h3C, 32'h0, 32'h2C1C0C0C, 1'b0},
    '{1'b0, 32'h38, 32'h0, 32'h00021807, 1'b0},
    '{1'b1, 32'h54, 32'h3, 32'h00000001, 1'b0},
    '{1'b1, 32'h68, 32'h000A0C00, 32'h000A0C00, 1'b0},
    '{1'b1, 32'h54, 32'h0, 32'h00000000, 1'b0},
    '{1'b0, 32'h38, 32'h0, 32'h0000007F, 1'b0}
  };

  power_mode_clock_control #(.TICK_CYCLES(4)) DUT (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .acpi_power_state(acpi_power_state),
    .double_rate_tick(double_rate_tick),
    .pixel_tick(pixel_tick),
    .block_clock_enable(block_clock_enable),
    .branch_clock_setting(branch_clock_setting),
    .system_memory_clock(system_memory_clock),
    .oscillator_enable(oscillator_enable),
    .times_four_multiplier(times_four_multiplier),
    .times_six_multiplier(times_six_multiplier),
    .times_seven_multiplier(times_seven_multiplier),
    .sleep_status(sleep_status)
  );

  always #2.5 pclk = ~pclk;

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic wrap_up;
    $display("mismatches %0d of %0d checks", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      err_count++;
      wrap_up();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_span(input string what, input int lo, input int hi,
                          input int got);
    checked++;
    if (got < lo || got > hi)
    begin
      err_count++;
      $display("unexpected %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : chk_span

  // apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // answer looked at mid-cycle, where it has settled
    @(negedge pclk);
    while (pready !== 1'b1 && k < 16)
    begin
      @(negedge pclk);
      k++;
    end
    chk_span("pready wait", 1, 15, k);
    rd = prdata;
    er = pslverr;
    // release right after the edge that takes the transfer
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk("read data", exp, rd);
    chk("read error", 32'h0, {31'h0, er});
  endtask : rdc

  // four double-rate pulses on one lane, pixel pulses counted
  task automatic pix_run(input int lane, output int cnt);
    cnt = 0;
    repeat (4)
    begin
      @(posedge pclk);
      double_rate_tick <= (lane == 1) ? 2'h2 : 2'h1;
      @(negedge pclk);
      if (pixel_tick[lane] === 1'b1) cnt++;
      @(posedge pclk);
      double_rate_tick <= 2'h0;
      @(negedge pclk);
      if (pixel_tick[lane] === 1'b1) cnt++;
    end
    repeat (4)
    begin
      @(negedge pclk);
      if (pixel_tick[lane] === 1'b1) cnt++;
    end
  endtask : pix_run

  task automatic chk_sleep(input logic [31:0] exp);
    chk("sleep status", exp, {31'h0, sleep_status});
    chk("oscillator", ~exp & 32'h1, {31'h0, oscillator_enable});
    chk("plls", (~exp & 32'h1) * 32'h7, {29'h0, times_four_multiplier,
        times_six_multiplier, times_seven_multiplier});
  endtask : chk_sleep

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    repeat (3) @(posedge pclk);
    chk_sleep(32'h0);
    chk("gate out", 32'h07, {25'h0, block_clock_enable});
    chk("branch out", 32'h2A1A0A09, branch_clock_setting);
    chk("sysmem out", 32'h09, {27'h0, system_memory_clock});
    presetn <= 1'b1;
    foreach (rows[i])
    begin
      if (rows[i].wr)
        apb(1'b1, rows[i].addr, rows[i].wd);
      apb(1'b0, rows[i].addr, 32'h0);
      chk("table data", rows[i].exp, rd);
      chk("table error", {31'h0, rows[i].err}, {31'h0, er});
    end
    chk("gate out", 32'h7F, {25'h0, block_clock_enable});
    chk("sysmem out", 32'h0C, {27'h0, system_memory_clock});
    apb(1'b1, 32'h54, 32'h1);
    repeat (3) @(posedge pclk);
    chk("gate out", 32'h07, {25'h0, block_clock_enable});
    chk("branch out", 32'h2C1C0C0C, branch_clock_setting);
    chk("sysmem out", 32'h0A, {27'h0, system_memory_clock});
    apb(1'b1, 32'h54, 32'h0);
    // tally runs one count per clock, upper half reads zero
    apb(1'b1, 32'h64, 32'hFFFFFFFF);
    apb(1'b0, 32'h64, 32'h0);
    t0 = rd;
    apb(1'b0, 32'h64, 32'h0);
    chk("tally step", 32'h4, (rd - t0) & 32'h0000FFFF);
    chk("tally upper", 32'h0, rd & 32'hFFFF0000);
    pix_run(0, n);
    chk("panel pixels", 32'h2, n);
    pix_run(1, n);
    chk("crt pixels", 32'h2, n);
    apb(1'b1, 32'h40, 32'h7B);
    pix_run(0, n);
    chk("gated pixels", 32'h0, n);
    apb(1'b1, 32'h40, 32'h7F);
    // sleep and wake with every recovery select
    for (int r = 0; r < 4; r++)
    begin
      apb(1'b1, 32'h50, r << 13);
      apb(1'b1, 32'h54, 32'h2);
      repeat (3) @(posedge pclk);
      chk_sleep(32'h1);
      chk("sleep gates", 32'h0, {25'h0, block_clock_enable});
      rdc(32'h54, 32'h6);
      apb(1'b1, 32'h54, 32'h0);
      n = 0;
      while (sleep_status !== 1'b0 && n < 1000)
      begin
        @(negedge pclk);
        n++;
      end
      chk_span("recovery", (r + 1) * 128, (r + 1) * 128 + 6, n);
      rdc(32'h54, 32'h0);
      chk_sleep(32'h0);
      chk("wake gates", 32'h7F, {25'h0, block_clock_enable});
    end
    // power-down request ignored while register control is chosen
    acpi_power_state <= 2'h2;
    repeat (10) @(posedge pclk);
    chk_sleep(32'h0);
    apb(1'b1, 32'h68, 32'h000A0C40);
    repeat (8) @(posedge pclk);
    chk_sleep(32'h1);
    acpi_power_state <= 2'h0;
    n = 0;
    while (sleep_status !== 1'b0 && n < 1000)
    begin
      @(negedge pclk);
      n++;
    end
    chk_span("acpi wake", 1, 999, n);
    apb(1'b1, 32'h68, 32'h000A0C00);
    // second reset in mid-run
    apb(1'b1, 32'h54, 32'h1);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdc(32'h54, 32'h0);
    rdc(32'h40, 32'h00021807);
    rdc(32'h68, 32'h00090900);
    wrap_up();
  end

endmodule : tb_power_mode_clock_control

`default_nettype wire
